// file: logic/sto_regs.v
`timescale 1ns/1ps
`include "sto_defs.vh"

// How it works
// - With override clear, calibration field reads the internal VCO calibration result.
// - With override set, written calibration value replaces internal result to synthesizer.
// - Bit 7 of calibration register reads 1 once calibration has completed.
// - Delta-sigma dithering is on only while the dither enable bit is high.
// - Read-only VCO type bit: 0 constant gain, 1 single varactor.
// - Order field selects zero, first, second order or MASH 1-1-1.
// - Lock detect enable bit drives the lock detector directly, no override needed.
// - Block-enable override bits force analog blocks on; all three reset zero.
// - Four-bit coefficient address selects the filter look-up table entry.
// - Coefficient value register reads and writes the addressed table entry.
// - With current correction override set, written field replaces internal correction.
// - Host force bit starts one calibration in idle with PLL on; self-clears.
module sto_regs #(
    parameter LUT_DEPTH = 16,
    parameter COEF_W = 6
) (
    input wire MCLK,
    input wire RSTN,
    input wire [6:0] ADDR,
    input wire WR_EN,
    input wire [7:0] WDATA,
    input wire RD_EN,
    output reg [7:0] RDATA,
    input wire [6:0] CAL_RESULT,
    input wire CAL_DONE,
    input wire [3:0] CORR_INTERNAL,
    input wire VCO_TYPE,
    input wire IDLE_MODE,
    input wire PLL_ON,
    output reg CAL_START,
    output reg [6:0] CAL_VALUE,
    output reg [3:0] CORR_VALUE,
    output reg [1:0] VCO_CUR_TRIM,
    output reg DITHER_EN,
    output reg OPEN_LOOP,
    output reg DS_MODULUS,
    output reg DS_ORDER_ZERO,
    output reg DS_ORDER_FIRST,
    output reg DS_ORDER_SECOND,
    output reg DS_ORDER_MASH,
    output reg DS_RST_MODE,
    output reg DS_RST,
    output reg LOCK_DET_EN,
    output reg [7:0] BLK_FORCE_ONE,
    output reg [7:0] BLK_FORCE_TWO,
    output reg [7:0] BLK_FORCE_THREE,
    output reg [3:0] COEF_SEL,
    output reg [COEF_W-1:0] COEF_DATA
);

    // Register storage
    reg [7:0] cur_trim;
    reg [7:0] cal_ovr;
    reg [7:0] syn_test;
    reg [7:0] blk_one;
    reg [7:0] blk_two;
    reg [7:0] blk_three;
    reg [3:0] coef_addr;
    reg [COEF_W-1:0] coef_lut [0:LUT_DEPTH-1];
    reg cal_force;
    reg cal_done_d;
    reg [7:0] next_rdata;
    // Table write strobe and the done edge
    wire wr_coef = WR_EN && (ADDR == `STO_ADDR_COEF_VAL);
    wire done_rise = CAL_DONE && !cal_done_d;
    // Force honoured only in idle with the PLL running
    wire force_set = WR_EN && (ADDR == `STO_ADDR_CAL_CTRL)
        && WDATA[`STO_CAL_FORCE_BIT] && IDLE_MODE && PLL_ON && !cal_force;
    wire [6:0] cal_view = cal_ovr[`STO_CAL_OVR_BIT] ?
        cal_ovr[`STO_CAL_MSB:`STO_CAL_LSB] : CAL_RESULT;
    // Order field, decoded one-hot below
    wire [1:0] ds_order = syn_test[`STO_ORDER_MSB:`STO_ORDER_LSB];
    // Loop index for the table reset
    integer i;

    ////////////////////////////////////////////////////////////////////////
    // Writable registers
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            cur_trim <= `STO_RST_CUR_TRIM;
            cal_ovr <= `STO_RST_CAL_OVR;
            syn_test <= `STO_RST_SYN_TEST;
            blk_one <= `STO_RST_BLK;
            blk_two <= `STO_RST_BLK;
            blk_three <= `STO_RST_BLK;
            coef_addr <= `STO_RST_COEF_ADDR;
        end else if (WR_EN) begin
            // Unmapped addresses fall to the default and change nothing
            case (ADDR)
                `STO_ADDR_CUR_TRIM: cur_trim <= WDATA;
                `STO_ADDR_CAL_OVR: cal_ovr <= WDATA;
                `STO_ADDR_SYN_TEST: syn_test <= WDATA;
                `STO_ADDR_BLK_ONE: blk_one <= WDATA;
                `STO_ADDR_BLK_TWO: blk_two <= WDATA;
                `STO_ADDR_BLK_THREE: blk_three <= WDATA;
                `STO_ADDR_COEF_ADDR: coef_addr <= WDATA[`STO_COEF_ADDR_MSB:`STO_COEF_ADDR_LSB];
                default: coef_addr <= coef_addr;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Filter coefficient table, written through the value window
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            for (i = 0; i < LUT_DEPTH; i = i + 1) begin
                coef_lut[i] <= `STO_RST_COEF_VAL;
            end
        end else if (wr_coef) begin
            coef_lut[coef_addr] <= WDATA[COEF_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Calibration force: one start pulse, bit held until done rises.
    // A fresh request in the clearing cycle is refused by !cal_force and dropped with no flag to show it.
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            cal_force <= 1'b0;
            cal_done_d <= 1'b0;
            CAL_START <= 1'b0;
        end else begin
            cal_done_d <= CAL_DONE;
            CAL_START <= force_set;
            if (force_set) begin
                cal_force <= 1'b1;
            end else if (done_rise) begin
                cal_force <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; reserved bits read zero
    always @* begin
        next_rdata = `STO_READ_ZERO;
        case (ADDR)
            `STO_ADDR_CAL_CTRL: next_rdata[`STO_CAL_FORCE_BIT] = cal_force;
            `STO_ADDR_CUR_TRIM: begin
                next_rdata = cur_trim;
                next_rdata[`STO_TRIM_RSVD_BIT] = 1'b0;
            end
            `STO_ADDR_CAL_OVR: next_rdata = {CAL_DONE, cal_view};
            `STO_ADDR_SYN_TEST: begin
                next_rdata = syn_test;
                next_rdata[`STO_VCO_TYPE_BIT] = VCO_TYPE;
            end
            `STO_ADDR_BLK_ONE: begin
                next_rdata = blk_one;
                next_rdata[`STO_BLK_ONE_RSVD_BIT] = 1'b0;
            end
            `STO_ADDR_BLK_TWO: next_rdata = blk_two;
            `STO_ADDR_BLK_THREE: next_rdata = blk_three;
            `STO_ADDR_COEF_ADDR: begin
                next_rdata[`STO_COEF_ADDR_MSB:`STO_COEF_ADDR_LSB] = coef_addr;
            end
            `STO_ADDR_COEF_VAL: next_rdata[COEF_W-1:0] = coef_lut[coef_addr];
            default: next_rdata = `STO_READ_ZERO;
        endcase
    end

    // Read data held until the next read
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= `STO_READ_ZERO;
        end else if (RD_EN) begin
            RDATA <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Controls to the analog side, registered for clean levels
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            // Quiet levels while in reset
            CAL_VALUE <= 7'h00;
            CORR_VALUE <= 4'h0;
            VCO_CUR_TRIM <= 2'h0;
            DITHER_EN <= 1'b0;
            OPEN_LOOP <= 1'b0;
            DS_MODULUS <= 1'b0;
            DS_ORDER_ZERO <= 1'b0;
            DS_ORDER_FIRST <= 1'b0;
            DS_ORDER_SECOND <= 1'b0;
            DS_ORDER_MASH <= 1'b0;
            DS_RST_MODE <= 1'b0;
            DS_RST <= 1'b0;
            LOCK_DET_EN <= 1'b0;
            BLK_FORCE_ONE <= `STO_RST_BLK;
            BLK_FORCE_TWO <= `STO_RST_BLK;
            BLK_FORCE_THREE <= `STO_RST_BLK;
            COEF_SEL <= `STO_RST_COEF_ADDR;
            COEF_DATA <= `STO_RST_COEF_VAL;
        end else begin
            // Override selects the host value over the internal result
            CAL_VALUE <= cal_view;
            CORR_VALUE <= cur_trim[`STO_CORR_OVR_BIT] ?
                cur_trim[`STO_CORR_MSB:`STO_CORR_LSB] : CORR_INTERNAL;
            VCO_CUR_TRIM <= cur_trim[`STO_TRIM_MSB:`STO_TRIM_LSB];
            DITHER_EN <= syn_test[`STO_DITHER_BIT];
            OPEN_LOOP <= syn_test[`STO_OPEN_LOOP_BIT];
            DS_MODULUS <= syn_test[`STO_MODULUS_BIT];
            // One-hot order select decoded from the two-bit field
            DS_ORDER_ZERO <= ds_order == `STO_ORDER_ZERO;
            DS_ORDER_FIRST <= ds_order == `STO_ORDER_FIRST;
            DS_ORDER_SECOND <= ds_order == `STO_ORDER_SECOND;
            DS_ORDER_MASH <= ds_order == `STO_ORDER_MASH;
            DS_RST_MODE <= syn_test[`STO_DS_RST_MODE_BIT];
            DS_RST <= syn_test[`STO_DS_RST_BIT];
            LOCK_DET_EN <= blk_two[`STO_LOCK_DET_BIT];
            // Reserved bit kept out of the forces
            BLK_FORCE_ONE <= blk_one & ~(8'h01 << `STO_BLK_ONE_RSVD_BIT);
            BLK_FORCE_TWO <= blk_two;
            BLK_FORCE_THREE <= blk_three;
            COEF_SEL <= coef_addr;
            COEF_DATA <= coef_lut[coef_addr];
        end
    end

endmodule

// file: logic/sto_defs.vh
`ifndef STO_DEFS_VH
`define STO_DEFS_VH

// Register offsets
`define STO_ADDR_CAL_CTRL 7'h55
`define STO_ADDR_CUR_TRIM 7'h5A
`define STO_ADDR_CAL_OVR 7'h5B
`define STO_ADDR_SYN_TEST 7'h5C
`define STO_ADDR_BLK_ONE 7'h5D
`define STO_ADDR_BLK_TWO 7'h5E
`define STO_ADDR_BLK_THREE 7'h5F
`define STO_ADDR_COEF_ADDR 7'h60
`define STO_ADDR_COEF_VAL 7'h61

// Reset values
`define STO_RST_CUR_TRIM 8'h00
`define STO_RST_CAL_OVR 8'h00
`define STO_RST_SYN_TEST 8'h0E
`define STO_RST_BLK 8'h00
`define STO_RST_COEF_ADDR 4'h0
`define STO_RST_COEF_VAL 6'h00
`define STO_READ_ZERO 8'h00

// Field positions
`define STO_CAL_FORCE_BIT 1
`define STO_CORR_OVR_BIT 6
`define STO_CORR_MSB 5
`define STO_CORR_LSB 2
`define STO_TRIM_MSB 1
`define STO_TRIM_LSB 0
`define STO_CAL_OVR_BIT 7
`define STO_CAL_MSB 6
`define STO_CAL_LSB 0
`define STO_DITHER_BIT 7
`define STO_VCO_TYPE_BIT 6
`define STO_OPEN_LOOP_BIT 5
`define STO_MODULUS_BIT 4
`define STO_ORDER_MSB 3
`define STO_ORDER_LSB 2
`define STO_DS_RST_MODE_BIT 1
`define STO_DS_RST_BIT 0
`define STO_LOCK_DET_BIT 6
`define STO_BLK_ONE_RSVD_BIT 4
`define STO_TRIM_RSVD_BIT 7
`define STO_COEF_ADDR_MSB 3
`define STO_COEF_ADDR_LSB 0

// Delta-sigma order codes
`define STO_ORDER_ZERO 2'h0
`define STO_ORDER_FIRST 2'h1
`define STO_ORDER_SECOND 2'h2
`define STO_ORDER_MASH 2'h3

`endif

// file: sim/sto_regs_checker.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Ties some output registers (calibration, correction, dither, order, lock, block one) to the write or read that caused them
module sto_regs_checker (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic CAL_DONE,
    input wire logic IDLE_MODE,
    input wire logic PLL_ON,
    input wire logic CAL_START,
    input wire logic [6:0] ADDR,
    input wire logic [6:0] CAL_VALUE,
    input wire logic [7:0] WDATA,
    input wire logic [7:0] RDATA,
    input wire logic [7:0] BLK_FORCE_ONE,
    input wire logic [3:0] CORR_VALUE,
    input wire logic DITHER_EN,
    input wire logic DS_ORDER_ZERO,
    input wire logic DS_ORDER_MASH,
    input wire logic LOCK_DET_EN
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    // Address decodes; outputs lag a write by two samples
    wire w5a = WR_EN && ADDR == 7'h5A;
    wire w5b = WR_EN && ADDR == 7'h5B;
    wire w5c = WR_EN && ADDR == 7'h5C;
    a_cal_override: assert property (w5b && WDATA[7] |-> ##2 CAL_VALUE == $past(WDATA[6:0], 2))
        else $error("calibration override not applied");
    a_done_flag: assert property (RD_EN && ADDR == 7'h5B |=> RDATA[7] == $past(CAL_DONE))
        else $error("done flag wrong");
    a_dither_follow: assert property (w5c |-> ##2 DITHER_EN == $past(WDATA[7], 2))
        else $error("dither enable wrong");
    a_order_decode: assert property (w5c |-> ##2 DS_ORDER_MASH == ($past(WDATA[3:2], 2) == 2'h3)
        && DS_ORDER_ZERO == ($past(WDATA[3:2], 2) == 2'h0)) else $error("order decode wrong");
    a_lock_direct: assert property (WR_EN && ADDR == 7'h5E |-> ##2 LOCK_DET_EN == $past(WDATA[6], 2))
        else $error("lock detect enable wrong");
    a_blk_one: assert property (WR_EN && ADDR == 7'h5D |-> ##2 BLK_FORCE_ONE == ($past(WDATA, 2) & 8'hEF))
        else $error("block force one wrong");
    a_corr_override: assert property (w5a && WDATA[6] |-> ##2 CORR_VALUE == $past(WDATA[5:2], 2))
        else $error("current correction override wrong");
    a_force_pulse: assert property (CAL_START |-> $past(WR_EN && ADDR == 7'h55 && WDATA[1]
        && IDLE_MODE && PLL_ON) ##1 !CAL_START) else $error("calibration start wrong");
    // Main scenarios reached
    c_start: cover property (CAL_START);
    c_mash: cover property (w5c ##2 DS_ORDER_MASH);
    c_coef_read: cover property (RD_EN && ADDR == 7'h61);
endmodule
bind sto_regs sto_regs_checker sto_regs_checker_i (.MCLK, .RSTN, .WR_EN, .RD_EN, .CAL_DONE,
    .IDLE_MODE, .PLL_ON, .CAL_START, .ADDR, .CAL_VALUE, .WDATA, .RDATA, .BLK_FORCE_ONE,
    .CORR_VALUE, .DITHER_EN, .DS_ORDER_ZERO, .DS_ORDER_MASH, .LOCK_DET_EN);

// file: sim/test_sto_regs.sv
`timescale 1ns/1ps
// Drives the register port at falling edges; reads and outputs checked
module test_sto_regs;
    logic MCLK = 0, RSTN = 0, WR_EN = 0, RD_EN = 0, CAL_DONE = 0;
    logic VCO_TYPE = 1, IDLE_MODE = 0, PLL_ON = 0;
    logic [6:0] ADDR = 0, CAL_RESULT = 7'h35;
    logic [7:0] WDATA = 0;
    logic [3:0] CORR_INTERNAL = 4'h9;
    logic [63:0] rexp = 64'h0035_4E00_0000_0000;
    wire [7:0] RDATA, BLK_FORCE_ONE, BLK_FORCE_TWO, BLK_FORCE_THREE;
    wire [6:0] CAL_VALUE;
    wire [3:0] CORR_VALUE, COEF_SEL;
    wire [5:0] COEF_DATA;
    wire [1:0] VCO_CUR_TRIM;
    wire CAL_START, DITHER_EN, OPEN_LOOP, DS_MODULUS, DS_ORDER_ZERO, DS_ORDER_FIRST;
    wire DS_ORDER_SECOND, DS_ORDER_MASH, DS_RST_MODE, DS_RST, LOCK_DET_EN;
    int fails = 0, n_tests = 0, i;
    int n_start = 0;
    sto_regs sto_regs_i (.MCLK, .RSTN, .ADDR, .WR_EN, .WDATA, .RD_EN, .RDATA, .CAL_RESULT,
        .CAL_DONE, .CORR_INTERNAL, .VCO_TYPE, .IDLE_MODE, .PLL_ON, .CAL_START, .CAL_VALUE,
        .CORR_VALUE, .VCO_CUR_TRIM, .DITHER_EN, .OPEN_LOOP, .DS_MODULUS, .DS_ORDER_ZERO,
        .DS_ORDER_FIRST, .DS_ORDER_SECOND, .DS_ORDER_MASH, .DS_RST_MODE, .DS_RST,
        .LOCK_DET_EN, .BLK_FORCE_ONE, .BLK_FORCE_TWO, .BLK_FORCE_THREE, .COEF_SEL, .COEF_DATA);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Extra falling edge lets the output registers catch up
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge MCLK);
        ADDR = a;
        WDATA = d;
        WR_EN = 1;
        @(negedge MCLK);
        WR_EN = 0;
        @(negedge MCLK);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(negedge MCLK);
        ADDR = a;
        RD_EN = 1;
        @(negedge MCLK);
        RD_EN = 0;
        chk(RDATA, e);
    endtask
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial forever #4 MCLK = ~MCLK;
    // Start pulses counted at falling edges, where the one-cycle pulse is settled
    always @(negedge MCLK) begin
        if (CAL_START === 1'b1)
            n_start++;
    end
    // Watchdog, so a hang still reaches the verdict
    initial begin
        #100000;
        fails++;
        $display("[ERR] %0t run overran", $time);
        complete_run;
    end
    initial begin
        repeat (3) @(negedge MCLK);
        RSTN = 1;
        for (i = 0; i < 8; i++) rd(7'(7'h5A + i), rexp[63 - 8 * i -: 8]);
        chk({DS_ORDER_MASH, DS_ORDER_ZERO, DS_RST_MODE, DS_RST}, 8'h0A);
        rd(7'h70, 8'h00);
        // Calibration override, done flag, then back to the internal result
        wr(7'h5B, 8'hA2);
        chk(CAL_VALUE, 8'h22);
        rd(7'h5B, 8'h22);
        CAL_DONE = 1;
        rd(7'h5B, 8'hA2);
        wr(7'h5B, 8'h00);
        CAL_RESULT = 7'h4C;
        rd(7'h5B, 8'hCC);
        chk(CAL_VALUE, 8'h4C);
        // Current correction, reserved bit 7 written high
        chk(CORR_VALUE, 8'h09);
        wr(7'h5A, 8'hD7);
        chk({CORR_VALUE, 2'h0, VCO_CUR_TRIM}, 8'h53);
        rd(7'h5A, 8'h57);
        // Every modulator order with dithering on
        for (i = 0; i < 4; i++) begin
            wr(7'h5C, 8'(8'h80 | (i << 2)));
            chk({DS_ORDER_MASH, DS_ORDER_SECOND, DS_ORDER_FIRST, DS_ORDER_ZERO}, 8'(1 << i));
            chk(DITHER_EN, 8'h01);
        end
        wr(7'h5C, 8'h0C);
        chk(DITHER_EN, 8'h00);
        rd(7'h5C, 8'h4C);
        VCO_TYPE = 0;
        rd(7'h5C, 8'h0C);
        wr(7'h5C, 8'h33);
        chk({OPEN_LOOP, DS_MODULUS, DS_ORDER_ZERO, DS_RST_MODE, DS_RST}, 8'h1F);
        wr(7'h5D, 8'hFF);
        rd(7'h5D, 8'hEF);
        chk(BLK_FORCE_ONE, 8'hEF);
        wr(7'h5E, 8'h40);
        chk({BLK_FORCE_TWO[7:1], LOCK_DET_EN}, 8'h41);
        wr(7'h5F, 8'hA5);
        chk(BLK_FORCE_THREE, 8'hA5);
        // Fill the table with reserved bits set, read back in reverse
        for (i = 0; i < 16; i++) begin
            wr(7'h60, 8'(8'hF0 + i));
            wr(7'h61, 8'(8'hC1 + 3 * i));
        end
        rd(7'h60, 8'h0F);
        for (i = 15; i >= 0; i--) begin
            wr(7'h60, 8'(i));
            chk(COEF_SEL, 8'(i));
            rd(7'h61, 8'(8'h01 + 3 * i));
            chk(COEF_DATA, 8'(8'h01 + 3 * i));
        end
        // Force refused outside idle, then accepted and cleared by done
        CAL_DONE = 0;
        wr(7'h55, 8'h02);
        chk(8'(n_start), 8'h00);
        rd(7'h55, 8'h00);
        IDLE_MODE = 1;
        wr(7'h55, 8'h02);
        chk(8'(n_start), 8'h00);
        PLL_ON = 1;
        wr(7'h55, 8'h02);
        chk(8'(n_start), 8'h01);
        rd(7'h55, 8'h02);
        // A second force while one is pending gives no second start
        wr(7'h55, 8'h02);
        chk(8'(n_start), 8'h01);
        CAL_DONE = 1;
        @(negedge MCLK);
        rd(7'h55, 8'h00);
        complete_run;
    end
endmodule
